// ===== core/pwd_pkg.sv
// Constants and types for the pickup wheel decoder.
// Assumes a 10 MHz single clock; configuration arrives as plain ports.
package pwd_pkg;
	localparam int unsigned NUM_INPUTS = 6;
	localparam int unsigned CNT_W = 10;
	localparam int unsigned PER_W = 24;
	localparam int unsigned ANG_W = 16;
	// Events per revolution limits
	localparam logic [9:0] EV_MIN = 10'h003;
	localparam logic [9:0] EV_MAX = 10'h1f4;
	// Gap threshold: interval above 3/2 of the previous one
	localparam int unsigned GAP_NUM = 3;
	localparam int unsigned GAP_DEN = 2;
	// Extended index window: 75 % of a tooth period, as 3/4
	localparam int unsigned EXT_NUM = 3;
	localparam int unsigned EXT_DEN = 4;
	// Plain index window: 25 % of a tooth period
	localparam int unsigned IDX_DEN = 4;
	// Wheel types
	typedef enum logic [2:0] {
		PWD_T_NONE = 3'b000,
		PWD_T_N = 3'b001,
		PWD_T_NP1 = 3'b010,
		PWD_T_NP1X = 3'b011,
		PWD_T_NM1 = 3'b100,
		PWD_T_NM2 = 3'b101,
		PWD_T_MAG = 3'b110,
		PWD_T_SINGLE = 3'b111
	} pwd_type_t;
	// Input polarity
	typedef enum logic [1:0] {
		PWD_P_PASSIVE = 2'b00,
		PWD_P_ACT_LOW = 2'b01,
		PWD_P_ACT_HIGH = 2'b10
	} pwd_pol_t;
	// Learning of set-two offset
	typedef enum logic [1:0] {
		PWD_L_IDLE = 2'b00,
		PWD_L_WAIT1 = 2'b01,
		PWD_L_WAIT2 = 2'b10,
		PWD_L_DONE = 2'b11
	} pwd_learn_t;
endpackage

// ===== core/pwd_channel.sv
// One pickup channel: edge detection, interval timing, index finding.
// Assumes the pin is synchronous to ref_clk and configuration is static.
`timescale 1ns/1ps
`default_nettype none
module pwd_channel (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Pin and configuration
	input wire logic pin,
	input wire logic [2:0] wheel_type,
	input wire logic [1:0] polarity,
	input wire logic [9:0] num_events,
	// Results
	output logic event_p,
	output logic index_p,
	output logic sync_err_p,
	output logic dir_err_p,
	output logic [23:0] period_q
);
	logic pin_q, seen_q;
	logic [23:0] timer_q, last_q;
	logic [9:0] cnt_q;
	logic [9:0] exp_cnt;
	logic active, edge_det, cfg_ok, is_gap, is_short, short_ok, want_gap;
	logic [25:0] gap_lim, last_x3;
	logic [25:0] ext_lim, idx_lim;
	logic np1_short, no_index;

	// Passive and active-low detect falling edges, active-high rising
	assign active = (wheel_type != pwd_pkg::PWD_T_NONE)
		&& cfg_ok;
	assign cfg_ok = (num_events >= pwd_pkg::EV_MIN)
		&& (num_events <= pwd_pkg::EV_MAX);
	assign edge_det = active && ((polarity == pwd_pkg::PWD_P_ACT_HIGH) ?
		(pin && !pin_q) : (!pin && pin_q));

	// Gap and index classification against the previous interval
	assign last_x3 = 26'(last_q) * 26'(pwd_pkg::GAP_NUM);
	assign gap_lim = 26'(timer_q) * 26'(pwd_pkg::GAP_DEN);
	assign is_gap = seen_q && (gap_lim > last_x3);
	assign ext_lim = 26'(timer_q) * 26'(pwd_pkg::EXT_DEN);
	assign idx_lim = 26'(timer_q) * 26'(pwd_pkg::IDX_DEN);
	assign is_short = seen_q && (idx_lim < 26'(last_q));
	// Extended mode takes the extra tooth anywhere up to 75 % of a period
	assign short_ok = (wheel_type == pwd_pkg::PWD_T_NP1X) ?
		(ext_lim < 26'(last_q) * 26'(pwd_pkg::EXT_NUM))
		: is_short;
	assign want_gap = (wheel_type == pwd_pkg::PWD_T_NM1)
		|| (wheel_type == pwd_pkg::PWD_T_NM2);
	// Extra tooth on plus-one wheels; plain and magnet wheels carry no index
	assign np1_short = short_ok && (wheel_type == pwd_pkg::PWD_T_NP1
		|| wheel_type == pwd_pkg::PWD_T_NP1X);
	assign no_index = (wheel_type == pwd_pkg::PWD_T_N)
		|| (wheel_type == pwd_pkg::PWD_T_MAG);

	// Expected events between index marks per wheel type
	always_comb begin
		case (wheel_type)
			pwd_pkg::PWD_T_NP1,
			pwd_pkg::PWD_T_NP1X: exp_cnt = num_events + 10'h001;
			pwd_pkg::PWD_T_NM1: exp_cnt = num_events - 10'h001;
			pwd_pkg::PWD_T_NM2: exp_cnt = num_events - 10'h002;
			pwd_pkg::PWD_T_SINGLE: exp_cnt = 10'h001;
			default: exp_cnt = num_events;
		endcase
	end

	// Interval timer and event counter
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pin_q <= 1'b0;
			seen_q <= 1'b0;
			timer_q <= 24'h000000;
			last_q <= 24'h000000;
			cnt_q <= 10'h000;
			period_q <= 24'h000000;
			event_p <= 1'b0;
			index_p <= 1'b0;
			sync_err_p <= 1'b0;
			dir_err_p <= 1'b0;
		end else begin
			pin_q <= pin;
			event_p <= edge_det;
			index_p <= 1'b0;
			sync_err_p <= 1'b0;
			dir_err_p <= 1'b0;
			if (timer_q != 24'hffffff)
				timer_q <= timer_q + 24'h000001;
			if (!active) begin
				seen_q <= 1'b0;
				cnt_q <= 10'h000;
			end else if (edge_det) begin
				timer_q <= 24'h000001;
				seen_q <= 1'b1;
				if (!np1_short) begin
					last_q <= timer_q;
					period_q <= timer_q;
				end
				if ((want_gap && is_gap) || np1_short
					|| wheel_type == pwd_pkg::PWD_T_SINGLE) begin
					index_p <= 1'b1;
					cnt_q <= 10'h001;
					// Events since the last index, this one excluded
					if (cnt_q != exp_cnt && cnt_q != 10'h000)
						sync_err_p <= 1'b1;
				end else if (no_index) begin
					// Plain and magnet wheels wrap per turn, no index
					cnt_q <= (cnt_q + 10'h001 >= exp_cnt) ? 10'h000
						: cnt_q + 10'h001;
				end else begin
					cnt_q <= cnt_q + 10'h001;
					// Too many teeth without index: wrong rotation or noise
					if (cnt_q >= exp_cnt && wheel_type != pwd_pkg::PWD_T_NP1X)
						dir_err_p <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== core/pwd_top.sv
// Pickup wheel decoder: six channels, two redundant sets, offset learning.
// Assumes synchronous pins and that configuration holds while running.
//
// Operation
// - An input set to unused ignores all its edges.
// - Plain tooth mode expects N evenly spaced events, no index.
// - Plus-one mode expects N+1 events; the extra event is the index.
// - Extended plus-one accepts the index within 75 % of a tooth period.
// - Extended plus-one mode never reports wrong rotation direction.
// - Minus-one mode finds the single gap and takes index from it.
// - Minus-two mode finds the double gap and takes index from it.
// - Magnet-count and single-magnet inputs pair on one disc.
// - Single-event mode expects one event per revolution.
// - Camshaft mounting of input 0 halves set1_rev_period; other inputs and position are not scaled.
// - Polarity is passive, active-low or active-high; edges follow it.
// - Each input belongs to set one or set two.
// - Index offset applies, adjusted by measured minus nominal angle.
// - Redundancy enable allows two sets; otherwise only set one works.
// - Offset configurable for set one; set two learns it.
// - First start syncs both sets, then redundancy available rises.
// - Learned offset persists and clears on new configuration.
// - No direct write path exists for the set-two offset.
`timescale 1ns/1ps
`default_nettype none
module pwd_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Pickup pins
	input wire logic [5:0] pickup_pin,
	// Per-input configuration, three bits per type
	input wire logic [17:0] cfg_type,
	input wire logic [11:0] cfg_polarity,
	input wire logic [59:0] cfg_events,
	input wire logic [5:0] cfg_camshaft,
	input wire logic [5:0] cfg_set_two,
	// Global configuration
	input wire logic cfg_redundancy_en,
	input wire logic cfg_load,
	input wire logic [15:0] cfg_index_offset,
	input wire logic [15:0] cfg_measured_angle,
	input wire logic [15:0] cfg_nominal_angle,
	input wire logic cfg_adjust_en,
	// Status
	output logic [5:0] index_out,
	output logic [5:0] sync_err_out,
	output logic [5:0] dir_err_out,
	output logic [23:0] set1_rev_period,
	output logic set1_index,
	output logic set2_index,
	output logic [15:0] set1_offset,
	output logic [15:0] set2_offset,
	output logic redundancy_available
);
	logic [5:0] ev_p, idx_p, serr_p, derr_p;
	logic [23:0] per [6];
	logic [5:0] idx_set1, idx_set2;
	logic [15:0] eff_offset;
	logic [15:0] learn_ctr_q, learned_q;
	logic learned_valid_q;
	logic [23:0] per_scaled;
	pwd_pkg::pwd_learn_t lst_q, lst_d;

	// One decoder per pickup input
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_ch
			pwd_channel u_ch (
				.ref_clk(ref_clk),
				.rstn(rstn),
				.pin(pickup_pin[gi]),
				.wheel_type(cfg_type[3*gi +: 3]),
				.polarity(cfg_polarity[2*gi +: 2]),
				.num_events(cfg_events[10*gi +: 10]),
				.event_p(ev_p[gi]),
				.index_p(idx_p[gi]),
				.sync_err_p(serr_p[gi]),
				.dir_err_p(derr_p[gi]),
				.period_q(per[gi])
			);
			// Group indexes by set; set two only counts when redundancy on
			assign idx_set1[gi] = idx_p[gi] && !cfg_set_two[gi];
			assign idx_set2[gi] = idx_p[gi] && cfg_set_two[gi]
				&& cfg_redundancy_en;
		end
	endgenerate

	// Offset with calibration difference added; wraps modulo 16 bits
	assign eff_offset = cfg_adjust_en ?
		cfg_index_offset + (cfg_measured_angle - cfg_nominal_angle)
		: cfg_index_offset;
	// Camshaft turns once per two crank revolutions: halve its period
	assign per_scaled = cfg_camshaft[0] ? {1'b0, per[0][23:1]}
		: per[0];

	// Learning sequence on first start after a configuration load
	always_comb begin
		lst_d = lst_q;
		case (lst_q)
			pwd_pkg::PWD_L_IDLE:
				if (cfg_redundancy_en && !learned_valid_q && |idx_set1)
					lst_d = pwd_pkg::PWD_L_WAIT2;
			pwd_pkg::PWD_L_WAIT2:
				if (|idx_set2)
					lst_d = pwd_pkg::PWD_L_DONE;
				else if (|idx_set1)
					lst_d = pwd_pkg::PWD_L_WAIT1;
			pwd_pkg::PWD_L_WAIT1:
				if (|idx_set2)
					lst_d = pwd_pkg::PWD_L_DONE;
			pwd_pkg::PWD_L_DONE:
				lst_d = pwd_pkg::PWD_L_DONE;
			default: lst_d = pwd_pkg::PWD_L_IDLE;
		endcase
		if (cfg_load)
			lst_d = pwd_pkg::PWD_L_IDLE;
	end

	// Learned offset: only written by the learning sequence
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			lst_q <= pwd_pkg::PWD_L_IDLE;
			learn_ctr_q <= 16'h0000;
			learned_q <= 16'h0000;
			learned_valid_q <= 1'b0;
		end else begin
			lst_q <= lst_d;
			// Starts at one so the set-two index cycle itself is counted
			if (lst_q == pwd_pkg::PWD_L_IDLE || |idx_set1)
				learn_ctr_q <= 16'h0001;
			else if (learn_ctr_q != 16'hffff)
				learn_ctr_q <= learn_ctr_q + 16'h0001;
			if (cfg_load) begin
				learned_q <= 16'h0000;
				learned_valid_q <= 1'b0;
			end else if (lst_q != pwd_pkg::PWD_L_DONE
				&& lst_q != pwd_pkg::PWD_L_IDLE && |idx_set2) begin
				// Set-one offset plus cycles since set-one index
				learned_q <= eff_offset + learn_ctr_q;
				learned_valid_q <= 1'b1;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			index_out <= 6'h00;
			sync_err_out <= 6'h00;
			dir_err_out <= 6'h00;
			set1_rev_period <= 24'h000000;
			set1_index <= 1'b0;
			set2_index <= 1'b0;
			set1_offset <= 16'h0000;
			set2_offset <= 16'h0000;
			redundancy_available <= 1'b0;
		end else begin
			index_out <= idx_p;
			sync_err_out <= serr_p;
			dir_err_out <= derr_p;
			set1_rev_period <= per_scaled;
			set1_index <= |idx_set1;
			set2_index <= |idx_set2;
			set1_offset <= eff_offset;
			set2_offset <= learned_q;
			redundancy_available <= learned_valid_q
				&& cfg_redundancy_en;
		end
	end
endmodule
`default_nettype wire

// ===== test/pwd_top_sva.sv
// Checker for the pickup wheel decoder top, bound to its ports.
// Assumes one clock domain with synchronous active low reset.
`timescale 1ns/1ps
`default_nettype none
module pwd_top_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Configuration
	input wire logic [17:0] cfg_type,
	input wire logic cfg_redundancy_en,
	input wire logic cfg_load,
	input wire logic [15:0] cfg_index_offset,
	input wire logic cfg_adjust_en,
	// Status
	input wire logic [5:0] index_out,
	input wire logic [5:0] sync_err_out,
	input wire logic [5:0] dir_err_out,
	input wire logic [15:0] set1_offset,
	input wire logic [15:0] set2_offset,
	input wire logic redundancy_available
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Pulses last one cycle; outputs are zero through reset
	property p_idx_pulse;
		!(|(index_out & $past(index_out)));
	endproperty
	a_idx_pulse: assert property (p_idx_pulse)
		else $error("index pulse held");
	property p_sync_pulse;
		!(|(sync_err_out & $past(sync_err_out)));
	endproperty
	a_sync_pulse: assert property (p_sync_pulse)
		else $error("sync error held");
	property p_dir_pulse;
		!(|(dir_err_out & $past(dir_err_out)));
	endproperty
	a_dir_pulse: assert property (p_dir_pulse)
		else $error("direction error held");
	// Two cycles of margin cover events already in the pipeline
	property p_unused;
		(cfg_type[2:0] == 3'h0) [*3] |->
			!(index_out[0] || sync_err_out[0] || dir_err_out[0]);
	endproperty
	a_unused: assert property (p_unused)
		else $error("unused input reported");
	property p_plain_no_index;
		(cfg_type[2:0] == 3'h1) [*3] |-> !index_out[0];
	endproperty
	a_plain_no_index: assert property (p_plain_no_index)
		else $error("index on plain wheel");
	property p_ext_no_dir;
		(cfg_type[2:0] == 3'h3) [*3] |-> !dir_err_out[0];
	endproperty
	a_ext_no_dir: assert property (p_ext_no_dir)
		else $error("direction error in extended mode");
	property p_red_off;
		!cfg_redundancy_en [*3] |-> !redundancy_available;
	endproperty
	a_red_off: assert property (p_red_off)
		else $error("redundancy without enable");
	property p_load_clear;
		cfg_load |=> ##[0:1] (set2_offset == 16'h0000 && !redundancy_available);
	endproperty
	a_load_clear: assert property (p_load_clear)
		else $error("learned offset kept after load");
	property p_set1_offset;
		(!cfg_adjust_en && $stable(cfg_index_offset)) [*3] |->
			set1_offset == cfg_index_offset;
	endproperty
	a_set1_offset: assert property (p_set1_offset)
		else $error("set one offset wrong");
endmodule
`default_nettype wire

// ===== test/pwd_wheel.sv
// Trigger wheel model: four teeth per turn on an active low pickup.
// Assumes run is driven just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module pwd_wheel #(parameter int PER = 900, parameter int TEETH = 4) (
	input wire logic ref_clk,
	input wire logic run,
	input wire logic [1:0] gap,
	input wire logic ext,
	output logic pin
);
	int c = 0;
	int k = 0;
	logic low;
	// Count 4 at 900 cycles keeps events under 15 kHz
	assign low = run && ((c < 2 && k < TEETH - int'(gap))
		|| (ext && k == 0 && c >= PER / 8 && c < PER / 8 + 2));
	// Pull-up holds the line high between teeth and when stopped
	initial pin = 1'b1;
	always @(posedge ref_clk) begin
		pin <= #1 !low;
		c <= (!run || c == PER - 1) ? 0 : c + 1;
		if (!run)
			k <= 0;
		else if (c == PER - 1)
			k <= (k == TEETH - 1) ? 0 : k + 1;
	end
endmodule
`default_nettype wire

// ===== test/tb_pickup_wheel_decoder_sync.sv
// Testbench for the pickup wheel decoder: wheel modes and redundancy.
// Assumes the wheel model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_pickup_wheel_decoder_sync;
	logic ref_clk, rstn = 0, run = 0, run2 = 0, cfg_load = 0;
	logic cfg_redundancy_en = 0, cfg_adjust_en = 0, ext = 0;
	logic [17:0] cfg_type = '0;
	logic [5:0] cfg_camshaft = '0, cfg_set_two = 6'h08;
	logic [15:0] cfg_index_offset = 16'h0005, set1_offset, set2_offset;
	logic [1:0] gap = '0;
	logic p0, p3, redundancy_available;
	logic [5:0] index_out, sync_err_out, dir_err_out;
	logic [23:0] set1_rev_period;
	wire logic [5:0] pickup_pin;
	int errors = 0, cmp_count = 0, idx_cnt = 0;
	int bad_cnt = 0, s1_cnt = 0, s2_cnt = 0;
	logic s1_idx, s2_idx;
	logic [59:0] cfg_events = {6{10'h004}};
	// Set two wheel lags by ten cycles
	assign pickup_pin = {2'b11, p3, 2'b11, p0};
	pwd_wheel w0 (.ref_clk, .run, .gap, .ext, .pin(p0));
	pwd_wheel w1 (.ref_clk, .run(run2), .gap, .ext, .pin(p3));
	pwd_top uut (.ref_clk, .rstn, .pickup_pin, .cfg_type,
		.cfg_polarity(12'h555), .cfg_events,
		.cfg_camshaft, .cfg_set_two, .cfg_redundancy_en, .cfg_load,
		.cfg_index_offset, .cfg_measured_angle(16'h0000),
		.cfg_nominal_angle(16'h0000), .cfg_adjust_en, .index_out,
		.sync_err_out, .dir_err_out, .set1_rev_period, .set1_index(s1_idx),
		.set2_index(s2_idx), .set1_offset, .set2_offset, .redundancy_available);
	// Clock and index counting
	initial begin
		ref_clk = 0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Errors count only after the first index, when the count is settled
	always @(posedge ref_clk) begin
		if ((sync_err_out[0] | dir_err_out[0]) === 1'b1 && idx_cnt > 0)
			bad_cnt++;
		if (index_out[0] === 1'b1)
			idx_cnt++;
		if (s1_idx === 1'b1)
			s1_cnt++;
		if (s2_idx === 1'b1)
			s2_cnt++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input string what, input logic [23:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic load();
		cfg_load = 1;
		tick(1);
		cfg_load = 0;
	endtask
	// Turn both wheels for whole revolutions, then let the pipe drain
	task automatic spin(input int revs, input logic [1:0] g, input logic e);
		gap = g;
		ext = e;
		idx_cnt = 0;
		bad_cnt = 0;
		s1_cnt = 0;
		s2_cnt = 0;
		run = 1;
		tick(10);
		run2 = 1;
		tick(revs * 3600 - 10);
		run = 0;
		run2 = 0;
		tick(20);
		$display("test with type %h done", cfg_type);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog at 95000 cycles, some 4700 beyond the planned run length
	initial begin
		tick(95000);
		errors++;
		summarize();
	end
	// Main sequence
	initial begin
		tick(10);
		rstn = 1;
		tick(2);
		spin(1, 2'd0, 1'b0);
		check("unused index", 24'(idx_cnt), 24'h0);
		for (int m = 1; m < 8; m++) begin
			cfg_type = 18'(m);
			spin(2, 2'(m == 7 ? 3 : (m == 4 || m == 5) ? m - 3 : 0),
				m == 2 || m == 3);
			check("index", 24'(idx_cnt > 0), 24'(m != 1 && m != 6));
			check("errors", 24'(bad_cnt), 24'h0);
			if (m == 1)
				check("period", set1_rev_period, 24'h000384);
		end
		// Count one too high on a gap wheel: the second index loses sync
		cfg_type = 18'h4;
		cfg_events[9:0] = 10'h005;
		spin(3, 2'd1, 1'b0);
		check("miscount", 24'(bad_cnt), 24'h1);
		// Count below range leaves the input unused
		cfg_type = 18'h7;
		cfg_events[9:0] = 10'h002;
		spin(1, 2'd3, 1'b0);
		check("range index", 24'(idx_cnt), 24'h0);
		cfg_events[9:0] = 10'h004;
		cfg_type = 18'h1;
		cfg_camshaft = 6'h01;
		spin(1, 2'd0, 1'b0);
		check("cam period", set1_rev_period, 24'h0001c2);
		cfg_camshaft = 6'h00;
		cfg_type = 18'h00804;
		cfg_redundancy_en = 1;
		load();
		spin(3, 2'd1, 1'b0);
		check("available", 24'(redundancy_available), 24'h1);
		check("sync errors", 24'(bad_cnt), 24'h0);
		check("set1 index", 24'(s1_cnt), 24'h2);
		check("set2 index", 24'(s2_cnt), 24'h2);
		check("set1 offset", 24'(set1_offset), 24'h5);
		check("set2 offset", 24'(set2_offset), 24'hf);
		load();
		tick(2);
		check("cleared", 24'({redundancy_available, set2_offset}), 24'h0);
		cfg_redundancy_en = 0;
		spin(2, 2'd1, 1'b0);
		check("single set", 24'(redundancy_available), 24'h0);
		check("set2 gated", 24'(s2_cnt), 24'h0);
		summarize();
	end
endmodule
bind pwd_top pwd_top_sva chk (.ref_clk, .rstn, .cfg_type, .cfg_redundancy_en,
	.cfg_load, .cfg_index_offset, .cfg_adjust_en, .index_out, .sync_err_out,
	.dir_err_out, .set1_offset, .set2_offset, .redundancy_available);
`default_nettype wire
